// [hdl/tld_line_ctrl.sv]
// Module: eight-link transmit line driver control with register port and interrupt
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps

module tld_line_ctrl #(
	parameter int unsigned NUM_LINKS = 8
) (
	// Clock and reset
	input  wire logic                                   ref_clk,
	input  wire logic                                   rst_b,
	// Register port
	input  wire logic [tld_pkg::ADDR_W-1:0]             reg_addr,
	input  wire logic [tld_pkg::DATA_W-1:0]             reg_wdata,
	input  wire logic                                   reg_wr,
	input  wire logic                                   reg_rd,
	output logic      [tld_pkg::DATA_W-1:0]             reg_rdata,
	// Global pins
	input  wire logic                                   global_tristate_pin,
	input  wire logic                                   reference_oscillator_input,
	// Per-link transmit side
	input  wire logic [NUM_LINKS-1:0]                   tx_pos,
	input  wire logic [NUM_LINKS-1:0]                   tx_neg,
	input  wire logic [NUM_LINKS-1:0]                   pulse_valid,
	input  wire logic [NUM_LINKS-1:0][tld_pkg::SUM_W-1:0] pulse_sum,
	input  wire logic [NUM_LINKS-1:0]                   e1_mode,
	// Per-link clocking and status from neighbours
	input  wire logic [NUM_LINKS-1:0]                   recovered_clk_lost,
	input  wire logic [NUM_LINKS-1:0]                   backplane_clk,
	input  wire logic [NUM_LINKS-1:0]                   line_rate_tick,
	input  wire logic [NUM_LINKS-1:0]                   remote_loopback_en,
	input  wire logic [NUM_LINKS-1:0]                   driver_overcurrent,
	// Line side and interrupt
	output tld_pkg::tld_link_out_s [NUM_LINKS-1:0]      link_out,
	output logic                                        irq
);

	// Oscillator monitor state
	logic [6:0] osc_win_q,  osc_win_d;
	logic [6:0] osc_high_q, osc_high_d;
	logic       osc_ok_q,   osc_ok_d;
	logic [6:0] osc_high_total;

	// Register port state
	logic [tld_pkg::DATA_W-1:0] rdata_q, rdata_d;
	logic                       irq_q,   irq_d;

	// Per-link state
	tld_pkg::tld_link_cfg_s cfg_q [NUM_LINKS];
	tld_pkg::tld_link_cfg_s cfg_d [NUM_LINKS];
	tld_pkg::tld_link_out_s out_q [NUM_LINKS];
	tld_pkg::tld_link_out_s out_d [NUM_LINKS];
	logic [NUM_LINKS-1:0] df_state_q, df_state_d;
	logic [NUM_LINKS-1:0] df_flag_q,  df_flag_d;
	logic [NUM_LINKS-1:0] ovf_flag_q, ovf_flag_d;
	logic [NUM_LINKS-1:0] bp_prev_q,  bp_prev_d;
	logic [6:0]           bp_cnt_q   [NUM_LINKS];
	logic [6:0]           bp_cnt_d   [NUM_LINKS];
	logic [NUM_LINKS-1:0] bp_lost, rec_loss_hiz, bp_loss_hiz, float_req, ovf_event, df_event;
	logic [NUM_LINKS-1:0] link_sel;
	logic [NUM_LINKS-1:0] irq_src;

	logic [2:0] addr_link;
	logic [7:0] addr_off;

	// All checks below sample on the one clock and pause during reset
	default clocking cb_link @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	assign addr_link = reg_addr[10:8];
	assign addr_off  = reg_addr[7:0];

	// Oscillator duty check; this assumes the sampled input toggles slowly enough
	// relative to ref_clk, a faster source needs a faster sampling clock
	assign osc_high_total = osc_high_q + {6'h00, reference_oscillator_input};

	always_comb begin
		osc_win_d  = osc_win_q + 7'h01;
		osc_high_d = osc_high_total;
		osc_ok_d   = osc_ok_q;
		if (osc_win_q == tld_pkg::OSC_WINDOW - 7'h01) begin
			osc_win_d  = 7'h00;
			osc_high_d = 7'h00;
			// Stuck levels give 0 or 100, both fail the band
			osc_ok_d   = (osc_high_total >= tld_pkg::OSC_DUTY_MIN_PCT) &&
			             (osc_high_total <= tld_pkg::OSC_DUTY_MAX_PCT);
		end
	end

	// Oscillator taken as absent until the first full window passes
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			osc_win_q  <= 7'h00;
			osc_high_q <= 7'h00;
			osc_ok_q   <= 1'b0;
		end else begin
			osc_win_q  <= osc_win_d;
			osc_high_q <= osc_high_d;
			osc_ok_q   <= osc_ok_d;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_LINKS; gi++) begin : g_link
			logic [14:0] scaled;
			logic        wr_here;

			assign link_sel[gi] = (addr_link == 3'(gi));
			assign wr_here      = reg_wr && link_sel[gi];
			// Nominal scale is 4, so each step is a quarter of nominal
			// Full product width; a narrower one wraps and hides overflow
			assign scaled = 15'(({6'h00, pulse_sum[gi]} *
			                     {9'h000, cfg_q[gi].amplitude_scale}) >> 2);
			assign ovf_event[gi] = pulse_valid[gi] && (scaled > 15'(tld_pkg::AMP_MAX));
			assign bp_lost[gi]   = bp_cnt_q[gi] > tld_pkg::BP_LOSS_CYCLES;
			assign rec_loss_hiz[gi] = cfg_q[gi].tx_clock_master &&
			                          cfg_q[gi].tx_clock_source_select &&
			                          recovered_clk_lost[gi];
			assign bp_loss_hiz[gi]  = !cfg_q[gi].tx_clock_master &&
			                          !cfg_q[gi].tx_clock_source_select &&
			                          bp_lost[gi] && !remote_loopback_en[gi];
			// Every float cause ORed, no frame alignment
			assign float_req[gi] = global_tristate_pin || !osc_ok_q ||
			                       cfg_q[gi].link_tristate_bit || rec_loss_hiz[gi] ||
			                       bp_loss_hiz[gi] || cfg_q[gi].tx_power_down;
			assign df_event[gi] = cfg_q[gi].driver_fault_edge_select ?
			                      (df_state_d[gi] != df_state_q[gi]) :
			                      (df_state_d[gi] && !df_state_q[gi]);
			assign irq_src[gi] = (df_flag_q[gi] && cfg_q[gi].driver_fault_irq_enable) ||
			                     (ovf_flag_q[gi] && cfg_q[gi].waveform_overflow_irq_enable);

			// Configuration writes of this link
			always_comb begin
				cfg_d[gi] = cfg_q[gi];
				if (wr_here) begin
					case (addr_off)
						tld_pkg::OFF_TX_CONFIG_ONE: begin
							cfg_d[gi].link_tristate_bit        = reg_wdata[tld_pkg::BIT_LINK_TRISTATE];
							cfg_d[gi].driver_protection_enable = reg_wdata[tld_pkg::BIT_DRV_PROTECT];
							cfg_d[gi].tx_power_down            = reg_wdata[tld_pkg::BIT_TX_POWER_DOWN];
						end
						tld_pkg::OFF_TX_CONFIG_TWO:   cfg_d[gi].amplitude_scale = reg_wdata[5:0];
						tld_pkg::OFF_TX_CONFIG_THREE: cfg_d[gi].cfg_three       = reg_wdata;
						tld_pkg::OFF_TX_CONFIG_FOUR:  cfg_d[gi].cfg_four        = reg_wdata;
						tld_pkg::OFF_TERMINATION_CFG: cfg_d[gi].term            = reg_wdata[2:0];
						tld_pkg::OFF_IRQ_ENABLE_ZERO:
							cfg_d[gi].driver_fault_irq_enable = reg_wdata[tld_pkg::BIT_DRV_FAULT];
						tld_pkg::OFF_IRQ_ENABLE_ONE:
							cfg_d[gi].waveform_overflow_irq_enable =
								reg_wdata[tld_pkg::BIT_WAVE_OVERFLOW];
						tld_pkg::OFF_IRQ_EDGE_SELECT:
							cfg_d[gi].driver_fault_edge_select = reg_wdata[tld_pkg::BIT_DRV_FAULT];
						tld_pkg::OFF_TX_TIMING_OPTION: begin
							cfg_d[gi].tx_clock_source_select = reg_wdata[tld_pkg::BIT_CLK_SOURCE_SEL];
							cfg_d[gi].tx_clock_master        = reg_wdata[tld_pkg::BIT_CLK_MASTER];
						end
						default: cfg_d[gi] = cfg_q[gi];
					endcase
				end
			end

			// Status, flags and backplane watchdog of this link
			always_comb begin
				df_state_d[gi] = cfg_q[gi].driver_protection_enable &&
				                 driver_overcurrent[gi];
				df_flag_d[gi]  = df_flag_q[gi];
				ovf_flag_d[gi] = ovf_flag_q[gi];
				// Write one clears; an event in the same cycle still sets
				if (wr_here && addr_off == tld_pkg::OFF_IRQ_FLAGS_ZERO &&
				    reg_wdata[tld_pkg::BIT_DRV_FAULT])
					df_flag_d[gi] = 1'b0;
				if (wr_here && addr_off == tld_pkg::OFF_IRQ_FLAGS_ONE &&
				    reg_wdata[tld_pkg::BIT_WAVE_OVERFLOW])
					ovf_flag_d[gi] = 1'b0;
				if (df_event[gi])
					df_flag_d[gi] = 1'b1;
				if (ovf_event[gi])
					ovf_flag_d[gi] = 1'b1;
				bp_prev_d[gi] = backplane_clk[gi];
				bp_cnt_d[gi]  = bp_cnt_q[gi];
				// Any transition restarts the idle count, saturate to avoid wrap
				if (backplane_clk[gi] != bp_prev_q[gi])
					bp_cnt_d[gi] = 7'h00;
				else if (line_rate_tick[gi] && bp_cnt_q[gi] != 7'h7F)
					bp_cnt_d[gi] = bp_cnt_q[gi] + 7'h01;
			end

			// Line side outputs; float on the very next edge
			always_comb begin
				out_d[gi].line_tip_oe_b    = float_req[gi];
				out_d[gi].line_ring_oe_b   = float_req[gi];
				out_d[gi].line_tip_out     = !float_req[gi] && tx_pos[gi];
				out_d[gi].line_ring_out    = !float_req[gi] && tx_neg[gi];
				out_d[gi].amplitude        = out_q[gi].amplitude;
				if (pulse_valid[gi])
					out_d[gi].amplitude = ovf_event[gi] ? 7'h7F : scaled[6:0];
				out_d[gi].current_limit_en = cfg_q[gi].driver_protection_enable;
				out_d[gi].term_sel         = cfg_q[gi].term[1:0];
				// T1/J1 has no external option, so bit 2 counts only in E1
				out_d[gi].term_internal_en = !e1_mode[gi] || !cfg_q[gi].term[2];
			end

			always_ff @(posedge ref_clk or negedge rst_b) begin
				if (!rst_b) begin
					cfg_q[gi]                          <= '0;
					cfg_q[gi].link_tristate_bit        <= 1'b1;
					cfg_q[gi].amplitude_scale          <= tld_pkg::SCALE_NOMINAL;
					cfg_q[gi].term                     <= tld_pkg::TERM_RESET;
					df_state_q[gi]                     <= 1'b0;
					df_flag_q[gi]                      <= 1'b0;
					ovf_flag_q[gi]                     <= 1'b0;
					bp_prev_q[gi]                      <= 1'b0;
					bp_cnt_q[gi]                       <= 7'h00;
					out_q[gi]                          <= '0;
					out_q[gi].line_tip_oe_b            <= 1'b1;
					out_q[gi].line_ring_oe_b           <= 1'b1;
					out_q[gi].term_internal_en         <= 1'b1;
				end else begin
					cfg_q[gi]      <= cfg_d[gi];
					df_state_q[gi] <= df_state_d[gi];
					df_flag_q[gi]  <= df_flag_d[gi];
					ovf_flag_q[gi] <= ovf_flag_d[gi];
					bp_prev_q[gi]  <= bp_prev_d[gi];
					bp_cnt_q[gi]   <= bp_cnt_d[gi];
					out_q[gi]      <= out_d[gi];
				end
			end

			assign link_out[gi] = out_q[gi];

			glob_float_a: assert property (global_tristate_pin |=>
				link_out[gi].line_tip_oe_b && link_out[gi].line_ring_oe_b)
				else $error("global tristate pin did not float driver");
			osc_float_a: assert property (!osc_ok_q |=> link_out[gi].line_tip_oe_b)
				else $error("driver active without reference oscillator");
			link_float_a: assert property (cfg_q[gi].link_tristate_bit |=>
				link_out[gi].line_tip_oe_b)
				else $error("link tristate bit did not float driver");
			rec_loss_a: assert property (rec_loss_hiz[gi] |=> link_out[gi].line_ring_oe_b)
				else $error("recovered clock loss did not float driver");
			bp_loss_a: assert property (!cfg_q[gi].tx_clock_master &&
				!cfg_q[gi].tx_clock_source_select && (bp_cnt_q[gi] == 7'h49) &&
				!remote_loopback_en[gi] |=> link_out[gi].line_tip_oe_b)
				else $error("backplane clock loss did not float driver");
			loop_keep_a: assert property (remote_loopback_en[gi] && !global_tristate_pin &&
				osc_ok_q && !cfg_q[gi].link_tristate_bit && !cfg_q[gi].tx_power_down &&
				!rec_loss_hiz[gi] |=> !link_out[gi].line_tip_oe_b)
				else $error("driver floated during remote loopback");
			pwr_float_a: assert property (cfg_q[gi].tx_power_down |=>
				link_out[gi].line_ring_oe_b)
				else $error("power down did not float driver");
			drv_enable_a: assert property (!float_req[gi] |=>
				!link_out[gi].line_tip_oe_b && !link_out[gi].line_ring_oe_b)
				else $error("driver not enabled with no float cause");
			scale_nom_a: assert property (pulse_valid[gi] &&
				cfg_q[gi].amplitude_scale == 6'h04 && pulse_sum[gi] < 9'h080 |=>
				link_out[gi].amplitude == $past(pulse_sum[gi][6:0]))
				else $error("nominal scale changed amplitude");
			ovf_flag_a: assert property (ovf_event[gi] |=> ovf_flag_q[gi] ##1
				(irq || !cfg_q[gi].waveform_overflow_irq_enable))
				else $error("overflow not flagged or not signalled");
			fault_rise_a: assert property (!df_state_q[gi] &&
				cfg_q[gi].driver_protection_enable && driver_overcurrent[gi] |=> df_flag_q[gi])
				else $error("rising driver fault not flagged");
			fault_fall_a: assert property (df_state_q[gi] && !df_state_d[gi] &&
				!df_flag_q[gi] && !cfg_q[gi].driver_fault_edge_select |=> !df_flag_q[gi])
				else $error("falling fault flagged in rising-only mode");
			fault_irq_a: assert property (df_flag_q[gi] &&
				cfg_q[gi].driver_fault_irq_enable |=> irq)
				else $error("driver fault interrupt missing");
			limit_a: assert property (cfg_q[gi].driver_protection_enable |=>
				link_out[gi].current_limit_en)
				else $error("current limit not enabled");
			term_t1_a: assert property (!e1_mode[gi] |=> link_out[gi].term_internal_en)
				else $error("external termination in T1 mode");
			term_e1_a: assert property (e1_mode[gi] && cfg_q[gi].term[2] |=>
				!link_out[gi].term_internal_en)
				else $error("E1 external termination not selected");
			// A floated driver must not carry stale marks or codes
			tip_quiet_a: assert property (float_req[gi] |=>
				!link_out[gi].line_tip_out && !link_out[gi].line_ring_out)
				else $error("floated driver still shows mark data");
			wave_sat_a: assert property (ovf_event[gi] |=>
				link_out[gi].amplitude == 7'h7F)
				else $error("overflowed amplitude not saturated");
			term_sel_a: assert property (!e1_mode[gi] |=>
				link_out[gi].term_sel == $past(cfg_q[gi].term[1:0]))
				else $error("termination code not passed to driver");
			fault_state_a: assert property (!cfg_q[gi].driver_protection_enable |=>
				!df_state_q[gi])
				else $error("fault state set with protection off");
		end
	endgenerate

	// Read mux and interrupt; unmapped offsets and links read as zero
	always_comb begin
		rdata_d = rdata_q;
		irq_d   = |irq_src;
		if (reg_rd) begin
			rdata_d = 8'h00;
			for (int i = 0; i < NUM_LINKS; i++) begin
				if (link_sel[i]) begin
					case (addr_off)
						tld_pkg::OFF_TX_CONFIG_ONE: begin
							rdata_d[tld_pkg::BIT_LINK_TRISTATE] = cfg_q[i].link_tristate_bit;
							rdata_d[tld_pkg::BIT_DRV_PROTECT]   = cfg_q[i].driver_protection_enable;
							rdata_d[tld_pkg::BIT_TX_POWER_DOWN] = cfg_q[i].tx_power_down;
						end
						tld_pkg::OFF_TX_CONFIG_TWO:   rdata_d = {2'b00, cfg_q[i].amplitude_scale};
						tld_pkg::OFF_TX_CONFIG_THREE: rdata_d = cfg_q[i].cfg_three;
						tld_pkg::OFF_TX_CONFIG_FOUR:  rdata_d = cfg_q[i].cfg_four;
						tld_pkg::OFF_TERMINATION_CFG: rdata_d = {5'h00, cfg_q[i].term};
						tld_pkg::OFF_IRQ_ENABLE_ZERO:
							rdata_d[tld_pkg::BIT_DRV_FAULT] = cfg_q[i].driver_fault_irq_enable;
						tld_pkg::OFF_IRQ_ENABLE_ONE:
							rdata_d[tld_pkg::BIT_WAVE_OVERFLOW] =
								cfg_q[i].waveform_overflow_irq_enable;
						tld_pkg::OFF_IRQ_EDGE_SELECT:
							rdata_d[tld_pkg::BIT_DRV_FAULT] = cfg_q[i].driver_fault_edge_select;
						tld_pkg::OFF_LINE_STATE_ZERO:
							rdata_d[tld_pkg::BIT_DRV_FAULT] = df_state_q[i];
						tld_pkg::OFF_IRQ_FLAGS_ZERO:
							rdata_d[tld_pkg::BIT_DRV_FAULT] = df_flag_q[i];
						tld_pkg::OFF_IRQ_FLAGS_ONE:
							rdata_d[tld_pkg::BIT_WAVE_OVERFLOW] = ovf_flag_q[i];
						tld_pkg::OFF_TX_TIMING_OPTION: begin
							rdata_d[tld_pkg::BIT_CLK_SOURCE_SEL] = cfg_q[i].tx_clock_source_select;
							rdata_d[tld_pkg::BIT_CLK_MASTER]     = cfg_q[i].tx_clock_master;
						end
						default: rdata_d = 8'h00;
					endcase
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_q <= 8'h00;
			irq_q   <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			irq_q   <= irq_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign irq       = irq_q;

	// Main scenarios
	cov_glob_c: cover property (@(posedge ref_clk) disable iff (!rst_b) global_tristate_pin);
	cov_osc_c:  cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(osc_ok_q));
	cov_bp_c:   cover property (@(posedge ref_clk) disable iff (!rst_b) |bp_loss_hiz);
	cov_irq_c:  cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(irq_q));
	cov_fault_c: cover property (@(posedge ref_clk) disable iff (!rst_b) |df_flag_q);

endmodule // tld_line_ctrl

// [hdl/tld_pkg.sv]
// Package: constants, register layout and carriers of the transmit line driver control
package tld_pkg;

	// Register bus geometry: link number in the upper bits, offset in the lower byte
	localparam int unsigned ADDR_W   = 11;
	localparam int unsigned OFF_W    = 8;
	localparam int unsigned DATA_W   = 8;

	// Per-link register offsets
	localparam logic [7:0] OFF_TX_CONFIG_ONE    = 8'h23;
	localparam logic [7:0] OFF_TX_CONFIG_TWO    = 8'h24;
	localparam logic [7:0] OFF_TX_CONFIG_THREE  = 8'h25;
	localparam logic [7:0] OFF_TX_CONFIG_FOUR   = 8'h26;
	localparam logic [7:0] OFF_TERMINATION_CFG  = 8'h32;
	localparam logic [7:0] OFF_IRQ_ENABLE_ZERO  = 8'h33;
	localparam logic [7:0] OFF_IRQ_ENABLE_ONE   = 8'h34;
	localparam logic [7:0] OFF_IRQ_EDGE_SELECT  = 8'h35;
	localparam logic [7:0] OFF_LINE_STATE_ZERO  = 8'h36;
	localparam logic [7:0] OFF_IRQ_FLAGS_ZERO   = 8'h3A;
	localparam logic [7:0] OFF_IRQ_FLAGS_ONE    = 8'h3B;
	localparam logic [7:0] OFF_TX_TIMING_OPTION = 8'h70;

	// Field positions
	localparam int unsigned BIT_LINK_TRISTATE   = 0; // tx_config_one
	localparam int unsigned BIT_DRV_PROTECT     = 1; // tx_config_one
	localparam int unsigned BIT_TX_POWER_DOWN   = 2; // tx_config_one
	localparam int unsigned BIT_DRV_FAULT       = 0; // irq enable/edge/flags zero, line state
	localparam int unsigned BIT_WAVE_OVERFLOW   = 0; // irq enable/flags one
	localparam int unsigned BIT_CLK_SOURCE_SEL  = 0; // tx_timing_option
	localparam int unsigned BIT_CLK_MASTER      = 1; // tx_timing_option

	// Reset values
	localparam logic [5:0] SCALE_NOMINAL        = 6'h04;
	localparam logic [2:0] TERM_RESET           = 3'h0;

	// Amplitude limit of the summed waveform
	localparam int unsigned AMP_W               = 7;
	localparam int unsigned SUM_W               = 9;
	localparam logic [12:0] AMP_MAX             = 13'h007F;

	// Reference oscillator duty check over a window of samples
	localparam logic [6:0] OSC_WINDOW           = 7'h64; // 100 samples
	localparam logic [6:0] OSC_DUTY_MIN_PCT     = 7'h1E; // 30 percent
	localparam logic [6:0] OSC_DUTY_MAX_PCT     = 7'h46; // 70 percent

	// Backplane clock loss, in line-rate cycles without a transition
	localparam logic [6:0] BP_LOSS_CYCLES       = 7'h48; // 72

	// Configuration carried per link
	typedef struct packed {
		logic       link_tristate_bit;
		logic       driver_protection_enable;
		logic       tx_power_down;
		logic [5:0] amplitude_scale;
		logic [7:0] cfg_three;
		logic [7:0] cfg_four;
		logic [2:0] term;
		logic       driver_fault_irq_enable;
		logic       waveform_overflow_irq_enable;
		logic       driver_fault_edge_select;
		logic       tx_clock_source_select;
		logic       tx_clock_master;
	} tld_link_cfg_s;

	// Line side bundle per link
	typedef struct packed {
		logic                 line_tip_out;
		logic                 line_tip_oe_b;
		logic                 line_ring_out;
		logic                 line_ring_oe_b;
		logic [AMP_W-1:0]     amplitude;
		logic [1:0]           term_sel;
		logic                 term_internal_en;
		logic                 current_limit_en;
	} tld_link_out_s;

endpackage

// [tb/tld_line_model.sv]
// Line and transformer model facing the eight transmit drivers
`timescale 1ns/100ps
module tld_line_model (
	// Clock
	input  wire logic                         ref_clk,
	// Driver side
	input  wire tld_pkg::tld_link_out_s [7:0] link_out,
	input  wire logic [7:0]                   fault_cmd,
	// Line side
	output logic      [7:0]                   driver_overcurrent,
	output logic      [7:0]                   line_tip
);
	// A shorted load draws excess current only while its driver is on
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			driver_overcurrent[i] = fault_cmd[i] & ~link_out[i].line_tip_oe_b;
		end
	end

	// Released line holds no level, so show the inverse of the last one
	always_ff @(posedge ref_clk) begin
		for (int i = 0; i < 8; i++) begin
			line_tip[i] <= link_out[i].line_tip_oe_b ? ~line_tip[i] : link_out[i].line_tip_out;
		end
	end
endmodule // tld_line_model

// [tb/tld_line_ctrl_test.sv]
// Self-checking bench of the transmit line driver control
`timescale 1ns/100ps
module tld_line_ctrl_test;
	logic                         ref_clk = 1'b0;
	logic                         rst_b, reg_wr, reg_rd, glob, osc_run, irq;
	logic                         osc = 1'b0;
	logic [10:0]                  reg_addr;
	logic [7:0]                   reg_wdata, reg_rdata, oe, tx_pos, tx_neg, valid, e1;
	logic [7:0]                   rcl, bpc, tick, rlb, fcmd, oc, tip;
	logic [7:0][8:0]              sum;
	tld_pkg::tld_link_out_s [7:0] lo;
	int                           fail_count = 0;
	int                           checks_done = 0;
	int                           cycles = 0;

	tld_line_ctrl dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.global_tristate_pin(glob), .reference_oscillator_input(osc), .tx_pos(tx_pos),
		.tx_neg(tx_neg), .pulse_valid(valid), .pulse_sum(sum), .e1_mode(e1),
		.recovered_clk_lost(rcl), .backplane_clk(bpc), .line_rate_tick(tick),
		.remote_loopback_en(rlb), .driver_overcurrent(oc), .link_out(lo), .irq(irq));
	tld_line_model line (.ref_clk(ref_clk), .link_out(lo), .fault_cmd(fcmd),
		.driver_overcurrent(oc), .line_tip(tip));

	// Clock, oscillator toggling while osc_run is set, and float vector
	initial forever #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) osc <= osc_run ? ~osc : osc;
	always_comb for (int i = 0; i < 8; i++) oe[i] = lo[i].line_tip_oe_b;

	// Hang guard: far above the roughly 700 cycles the run needs
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fail_count++;
			give_verdict();
		end
	end

	task automatic give_verdict();
		if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Bus cycles: one strobe cycle, read data in the next cycle, held until the next read
	task automatic wr(input logic [2:0] lk, input logic [7:0] off, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= {lk, off};
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] lk, input logic [7:0] off, input logic [8:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= {lk, off};
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task automatic t_enable();
		for (int i = 0; i < 8; i++) wr(i[2:0], tld_pkg::OFF_TX_CONFIG_ONE, 8'h00);
		cyc(2);
		chk(oe, 9'h000);
		@(posedge ref_clk);
		glob <= 1'b1;
		tx_pos <= 8'hAA;
		tx_neg <= 8'h55;
		cyc(1);
		chk(oe, 9'h0FF);
		chk({lo[1].line_tip_out, lo[0].line_ring_out}, 9'h000);
		@(posedge ref_clk);
		glob <= 1'b0;
		cyc(1);
		chk(oe, 9'h000);
		chk({lo[1].line_tip_out, lo[0].line_ring_out}, 9'h003);
		wr(3'h1, tld_pkg::OFF_TX_CONFIG_ONE, 8'h01);
		cyc(2);
		chk(oe, 9'h002);
		chk(tip & 8'hFD, 9'h0A8);
		wr(3'h1, tld_pkg::OFF_TX_CONFIG_ONE, 8'h04);
		cyc(2);
		chk(oe, 9'h002);
		wr(3'h1, tld_pkg::OFF_TX_CONFIG_ONE, 8'h00);
	endtask

	// Scaling steps and a masked, then unmasked, overflow
	task automatic t_amp();
		@(posedge ref_clk);
		valid[2] <= 1'b1;
		sum[2] <= 9'h014;
		cyc(2);
		chk(lo[2].amplitude, 9'h014);
		wr(3'h2, tld_pkg::OFF_TX_CONFIG_TWO, 8'h05);
		cyc(2);
		chk(lo[2].amplitude, 9'h019);
		wr(3'h2, tld_pkg::OFF_TX_CONFIG_TWO, 8'h03);
		cyc(2);
		chk(lo[2].amplitude, 9'h00F);
		@(posedge ref_clk);
		sum[2] <= 9'h0C8;
		@(posedge ref_clk);
		valid[2] <= 1'b0;
		cyc(3);
		chk(lo[2].amplitude, 9'h07F);
		chk(irq, 9'h000);
		wr(3'h2, tld_pkg::OFF_IRQ_ENABLE_ONE, 8'h01);
		cyc(2);
		chk(irq, 9'h001);
		rd(3'h2, tld_pkg::OFF_IRQ_FLAGS_ONE, 9'h001);
		wr(3'h2, tld_pkg::OFF_IRQ_FLAGS_ONE, 8'h01);
		cyc(2);
		chk(irq, 9'h000);
		wr(3'h2, tld_pkg::OFF_TX_CONFIG_TWO, 8'h20);
		@(posedge ref_clk);
		valid[2] <= 1'b1;
		sum[2] <= 9'h100;
		@(posedge ref_clk);
		valid[2] <= 1'b0;
		cyc(2);
		rd(3'h2, tld_pkg::OFF_IRQ_FLAGS_ONE, 9'h001);
		chk(lo[2].amplitude, 9'h07F);
		wr(3'h2, tld_pkg::OFF_IRQ_FLAGS_ONE, 8'h01);
	endtask

	// Fault on link 0 in rising-only, then both-edge mode
	task automatic t_fault();
		wr(3'h0, tld_pkg::OFF_IRQ_ENABLE_ZERO, 8'h01);
		wr(3'h0, tld_pkg::OFF_TX_CONFIG_ONE, 8'h02);
		@(posedge ref_clk);
		fcmd[0] <= 1'b1;
		cyc(3);
		chk(lo[0].current_limit_en, 9'h001);
		chk(irq, 9'h001);
		rd(3'h0, tld_pkg::OFF_LINE_STATE_ZERO, 9'h001);
		wr(3'h0, tld_pkg::OFF_IRQ_FLAGS_ZERO, 8'h01);
		@(posedge ref_clk);
		fcmd[0] <= 1'b0;
		cyc(3);
		chk(irq, 9'h000);
		wr(3'h0, tld_pkg::OFF_IRQ_EDGE_SELECT, 8'h01);
		@(posedge ref_clk);
		fcmd[0] <= 1'b1;
		cyc(3);
		wr(3'h0, tld_pkg::OFF_IRQ_FLAGS_ZERO, 8'h01);
		@(posedge ref_clk);
		fcmd[0] <= 1'b0;
		cyc(3);
		chk(irq, 9'h001);
		wr(3'h0, tld_pkg::OFF_IRQ_FLAGS_ZERO, 8'h01);
	endtask

	task automatic t_term();
		for (int c = 0; c < 4; c++) begin
			wr(3'h3, tld_pkg::OFF_TERMINATION_CFG, 8'h04 | c[7:0]);
			cyc(2);
			chk(lo[3].term_sel, c[8:0]);
			chk(lo[3].term_internal_en, 9'h001);
		end
		@(posedge ref_clk);
		e1[3] <= 1'b1;
		cyc(2);
		chk(lo[3].term_internal_en, 9'h000);
		wr(3'h3, tld_pkg::OFF_TERMINATION_CFG, 8'h02);
		cyc(2);
		chk(lo[3].term_internal_en, 9'h001);
	endtask

	// Backplane idle count, loopback exception, lost line clock
	task automatic t_clk();
		@(posedge ref_clk);
		tick[4] <= 1'b1;
		cyc(73);
		chk(oe, 9'h000);
		cyc(1);
		chk(oe, 9'h010);
		@(posedge ref_clk);
		rlb[4] <= 1'b1;
		cyc(2);
		chk(oe, 9'h000);
		@(posedge ref_clk);
		bpc[4] <= 1'b1;
		@(posedge ref_clk);
		tick[4] <= 1'b0;
		rlb[4] <= 1'b0;
		wr(3'h5, tld_pkg::OFF_TX_TIMING_OPTION, 8'h03);
		@(posedge ref_clk);
		rcl[5] <= 1'b1;
		cyc(2);
		chk(oe, 9'h020);
	endtask

	initial begin
		{rst_b, reg_wr, reg_rd, glob, tx_pos, tx_neg, valid, e1, rcl, bpc, tick} = '0;
		{rlb, fcmd, reg_addr, reg_wdata, sum} = '0;
		osc_run = 1'b1;
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		cyc(1);
		chk(oe, 9'h0FF);
		rd(3'h0, tld_pkg::OFF_TX_CONFIG_TWO, 9'h004);
		rd(3'h0, 8'h50, 9'h000);
		cyc(210);
		t_enable();
		t_amp();
		t_fault();
		t_term();
		t_clk();
		@(posedge ref_clk);
		osc_run <= 1'b0;
		cyc(250);
		chk(oe, 9'h0FF);
		give_verdict();
	end
endmodule // tld_line_ctrl_test
